// ---- core/sdm_pkg.sv ----
// Overview of operation
// - all inputs are captured on the rising clock edge only.
// - four banks, 8192 rows by 512 columns of 16-bit words.
// - ACTIVE takes bank from two bank-select bits, row from thirteen address lines.
// - READ or WRITE takes starting column from nine low address lines.
// - precharge of all banks after the wait leaves every bank idle.
// - mode register written only by load-mode command, held until reloaded.
// - mode fields: length 0-2, order 3, latency 4-6, mode 7-8, write mode 9.
// - each READ or WRITE below full row spans at most the programmed burst length; a full-row burst runs until stopped.
// - lengths 1, 2, 4, 8 for both orders; full row sequential only.
// - burst terminate ends a full-row burst at any length.
// - upper column bits select the block, lower bits the start offset.
// - burst stays inside its block, wrapping at the block boundary.
// - full-row burst wraps past the last column within the open row.
// - read latency of two or three clocks to first data.
// - normal operation only when mode bits 7 and 8 are zero.
// - write burst mode bit makes writes single-location, reads keep length.
package sdm_pkg;
    localparam int NUM_BANKS = 4;
    localparam int BANK_W = 2;
    localparam int ROW_W = 13;
    localparam int COL_W = 9;
    localparam int DATA_W = 16;
    localparam int LANES = 2;
    localparam int MODE_W = 15;
    localparam int ADDR_W = BANK_W + ROW_W + COL_W;
    localparam int DEPTH = NUM_BANKS * (2 ** ROW_W) * (2 ** COL_W);
    // mode register field positions
    localparam int BL_LSB = 0;
    localparam int BO_BIT = 3;
    localparam int CL_LSB = 4;
    localparam int OPM_LSB = 7;
    localparam int WBM_BIT = 9;
    localparam int RS_LSB = 13;
    localparam int AP_BIT = 10;
    localparam logic [MODE_W-1:0] MODE_RST = 15'h0000;
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [2:0] CL_3 = 3'h3;
    localparam logic [1:0] OPM_NORMAL = 2'h0;
    localparam logic [1:0] RS_BASE = 2'h0;
    typedef enum logic [2:0] {
        CMD_NOP = 3'b000,
        CMD_ACT = 3'b001,
        CMD_RD = 3'b010,
        CMD_WR = 3'b011,
        CMD_BST = 3'b100,
        CMD_PRE = 3'b101,
        CMD_REF = 3'b110,
        CMD_LMR = 3'b111
    } sdm_cmd_t;
    typedef enum logic [0:0] {
        ENG_IDLE = 1'b0,
        ENG_BURST = 1'b1
    } sdm_eng_t;
endpackage : sdm_pkg

// ---- core/sdm_mem_if.sv ----
`timescale 1ns/1ps
interface sdm_mem_if;
    import sdm_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic we;
    logic [LANES-1:0] be;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    modport ctrl (output addr, output we, output be, output wdata, input rdata);
    modport mem (input addr, input we, input be, input wdata, output rdata);
endinterface : sdm_mem_if

// ---- core/sdm_array.sv ----
`timescale 1ns/1ps
module sdm_array (
    input wire logic i_mclk,
    sdm_mem_if.mem mem
);
    import sdm_pkg::*;

    logic [DATA_W-1:0] cells [0:DEPTH-1];

    // read returns old contents on a same-cycle write; reads and writes never overlap
    always_ff @(posedge i_mclk) begin
        if (mem.we) begin
            for (int l = 0; l < LANES; l++) begin
                if (mem.be[l]) begin
                    cells[mem.addr][l*8 +: 8] <= mem.wdata[l*8 +: 8];
                end
            end
        end
        mem.rdata <= cells[mem.addr];
    end
endmodule : sdm_array

// ---- core/sdm_device.sv ----
`timescale 1ns/1ps
module sdm_device (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_cke,
    input wire logic i_cs_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic i_bank_select_bit0,
    input wire logic i_bank_select_bit1,
    input wire logic [sdm_pkg::ROW_W-1:0] i_row_column_address_lines,
    input wire logic [sdm_pkg::LANES-1:0] i_dqm,
    input wire logic [sdm_pkg::DATA_W-1:0] i_bidirectional_data_lines,
    output logic [sdm_pkg::DATA_W-1:0] o_bidirectional_data_lines,
    output logic [sdm_pkg::LANES-1:0] o_bidirectional_data_lines_oe,
    output logic o_all_banks_idle,
    output logic [sdm_pkg::MODE_W-1:0] o_operating_mode_register
);
    import sdm_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    function automatic sdm_cmd_t f_decode(input logic cs_n, input logic ras_n,
                                          input logic cas_n, input logic we_n);
        sdm_cmd_t c;
        c = CMD_NOP;
        if (!cs_n) begin
            case ({ras_n, cas_n, we_n})
                3'b011: c = CMD_ACT;
                3'b101: c = CMD_RD;
                3'b100: c = CMD_WR;
                3'b110: c = CMD_BST;
                3'b010: c = CMD_PRE;
                3'b001: c = CMD_REF;
                3'b000: c = CMD_LMR;
                default: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction : f_decode

    // reserved length codes fall back to a single access
    function automatic logic [COL_W-1:0] f_mask(input logic [2:0] bl, input logic single);
        logic [COL_W-1:0] m;
        m = 9'h000;
        if (!single) begin
            case (bl)
                BL_2: m = 9'h001;
                BL_4: m = 9'h003;
                BL_8: m = 9'h007;
                BL_FULL: m = 9'h1FF;
                default: m = 9'h000;
            endcase
        end
        return m;
    endfunction : f_mask

    function automatic logic [COL_W-1:0] f_col(input logic [COL_W-1:0] start,
                                               input logic [COL_W-1:0] cnt,
                                               input logic [COL_W-1:0] mask,
                                               input logic inter);
        logic [COL_W-1:0] low;
        low = inter ? (start ^ cnt) : (start + cnt);
        return (start & ~mask) | (low & mask);
    endfunction : f_col

    // ****************************************
    // input capture
    // ****************************************
    logic cke_r;
    logic cs_n_r;
    logic ras_n_r;
    logic cas_n_r;
    logic we_n_r;
    logic [BANK_W-1:0] ba_r;
    logic [ROW_W-1:0] addr_r;
    logic [LANES-1:0] dqm_r;
    logic [DATA_W-1:0] dq_r;

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            cke_r <= 1'b0;
            cs_n_r <= 1'b1;
            ras_n_r <= 1'b1;
            cas_n_r <= 1'b1;
            we_n_r <= 1'b1;
            ba_r <= '0;
            addr_r <= '0;
            dqm_r <= '0;
            dq_r <= '0;
        end else begin
            cke_r <= i_cke;
            cs_n_r <= i_cs_n;
            ras_n_r <= i_ras_n;
            cas_n_r <= i_cas_n;
            we_n_r <= i_we_n;
            ba_r <= {i_bank_select_bit1, i_bank_select_bit0};
            addr_r <= i_row_column_address_lines;
            dqm_r <= i_dqm;
            dq_r <= i_bidirectional_data_lines;
        end
    end

    // clock gate low acts as suspend: no command, burst frozen
    sdm_cmd_t cmd;
    assign cmd = cke_r ? f_decode(cs_n_r, ras_n_r, cas_n_r, we_n_r) : CMD_NOP;

    // ****************************************
    // mode register and bank state
    // ****************************************
    logic [MODE_W-1:0] mode_r;
    logic [MODE_W-1:0] mode_nxt;
    logic [NUM_BANKS-1:0] open_r;
    logic [NUM_BANKS-1:0] open_nxt;
    logic [ROW_W-1:0] row_r [NUM_BANKS];
    logic [ROW_W-1:0] row_nxt [NUM_BANKS];

    logic [2:0] burst_length_field;
    logic burst_order_bit;
    logic [2:0] read_latency_field;
    logic operating_mode_low_bit;
    logic operating_mode_high_bit;
    logic write_burst_mode_bit;
    logic normal_mode;

    assign burst_length_field = mode_r[BL_LSB +: 3];
    assign burst_order_bit = mode_r[BO_BIT];
    assign read_latency_field = mode_r[CL_LSB +: 3];
    assign operating_mode_low_bit = mode_r[OPM_LSB];
    assign operating_mode_high_bit = mode_r[OPM_LSB + 1];
    assign write_burst_mode_bit = mode_r[WBM_BIT];
    assign normal_mode = ({operating_mode_high_bit, operating_mode_low_bit}
                          == OPM_NORMAL);

    always_comb begin
        mode_nxt = mode_r;
        open_nxt = open_r;
        row_nxt = row_r;
        // only the base register select is stored here
        if (cmd == CMD_LMR && ba_r == RS_BASE) begin
            mode_nxt = {ba_r, addr_r};
        end
        if (cmd == CMD_ACT) begin
            open_nxt[ba_r] = 1'b1;
            row_nxt[ba_r] = addr_r;
        end
        if (cmd == CMD_PRE) begin
            if (addr_r[AP_BIT]) begin
                open_nxt = '0;
            end else begin
                open_nxt[ba_r] = 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            mode_r <= MODE_RST;
            open_r <= '0;
            for (int b = 0; b < NUM_BANKS; b++) begin
                row_r[b] <= '0;
            end
        end else begin
            mode_r <= mode_nxt;
            open_r <= open_nxt;
            row_r <= row_nxt;
        end
    end

    assign o_all_banks_idle = ~|open_r;
    assign o_operating_mode_register = mode_r;

    // ****************************************
    // burst engine
    // ****************************************
    logic start_rd;
    logic start_wr;
    logic start;
    logic new_single;
    logic [COL_W-1:0] new_mask;

    sdm_eng_t eng_r;
    sdm_eng_t eng_nxt;
    logic eng_wr_r;
    logic eng_wr_nxt;
    logic eng_inter_r;
    logic eng_inter_nxt;
    logic [BANK_W-1:0] eng_bank_r;
    logic [BANK_W-1:0] eng_bank_nxt;
    logic [COL_W-1:0] eng_start_r;
    logic [COL_W-1:0] eng_start_nxt;
    logic [COL_W-1:0] eng_mask_r;
    logic [COL_W-1:0] eng_mask_nxt;
    logic [COL_W-1:0] eng_cnt_r;
    logic [COL_W-1:0] eng_cnt_nxt;
    logic eng_full;
    logic eng_stop;

    logic beat_v;
    logic beat_wr;
    logic [BANK_W-1:0] beat_bank;
    logic [COL_W-1:0] beat_col;

    // accesses to a closed bank are dropped
    assign start_rd = cmd == CMD_RD && normal_mode && open_r[ba_r];
    assign start_wr = cmd == CMD_WR && normal_mode && open_r[ba_r];
    assign start = start_rd | start_wr;
    assign new_single = start_wr && write_burst_mode_bit;
    assign new_mask = f_mask(burst_length_field, new_single);
    assign eng_full = eng_mask_r == 9'h1FF;
    assign eng_stop = cmd == CMD_BST
        || (cmd == CMD_PRE && (addr_r[AP_BIT] || ba_r == eng_bank_r));

    always_comb begin
        eng_nxt = eng_r;
        eng_wr_nxt = eng_wr_r;
        eng_inter_nxt = eng_inter_r;
        eng_bank_nxt = eng_bank_r;
        eng_start_nxt = eng_start_r;
        eng_mask_nxt = eng_mask_r;
        eng_cnt_nxt = eng_cnt_r;
        beat_v = 1'b0;
        beat_wr = eng_wr_r;
        beat_bank = eng_bank_r;
        beat_col = f_col(eng_start_r, eng_cnt_r, eng_mask_r, eng_inter_r);
        if (start) begin
            // a new command cuts any running burst short
            beat_v = 1'b1;
            beat_wr = start_wr;
            beat_bank = ba_r;
            beat_col = addr_r[COL_W-1:0];
            eng_wr_nxt = start_wr;
            eng_bank_nxt = ba_r;
            eng_start_nxt = addr_r[COL_W-1:0];
            eng_mask_nxt = new_mask;
            // interleave is not offered for a full row
            eng_inter_nxt = burst_order_bit && new_mask != 9'h1FF;
            eng_cnt_nxt = 9'h001;
            eng_nxt = (new_mask == 9'h000) ? ENG_IDLE : ENG_BURST;
        end else begin
            case (eng_r)
                ENG_IDLE: begin
                    eng_nxt = ENG_IDLE;
                end
                ENG_BURST: begin
                    if (eng_stop) begin
                        eng_nxt = ENG_IDLE;
                    end else if (cke_r) begin
                        beat_v = 1'b1;
                        eng_cnt_nxt = eng_cnt_r + 9'h001;
                        if (!eng_full && eng_cnt_r == eng_mask_r) begin
                            eng_nxt = ENG_IDLE;
                        end
                    end
                end
                default: begin
                    eng_nxt = ENG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            eng_r <= ENG_IDLE;
            eng_wr_r <= 1'b0;
            eng_inter_r <= 1'b0;
            eng_bank_r <= '0;
            eng_start_r <= '0;
            eng_mask_r <= '0;
            eng_cnt_r <= '0;
        end else begin
            eng_r <= eng_nxt;
            eng_wr_r <= eng_wr_nxt;
            eng_inter_r <= eng_inter_nxt;
            eng_bank_r <= eng_bank_nxt;
            eng_start_r <= eng_start_nxt;
            eng_mask_r <= eng_mask_nxt;
            eng_cnt_r <= eng_cnt_nxt;
        end
    end

    // ****************************************
    // array and read pipeline
    // ****************************************
    sdm_mem_if mif ();

    assign mif.addr = {beat_bank, row_r[beat_bank], beat_col};
    assign mif.we = beat_v && beat_wr;
    assign mif.be = ~dqm_r;
    assign mif.wdata = dq_r;

    sdm_array u_array (
        .i_mclk(i_mclk),
        .mem(mif.mem)
    );

    logic rv1_r;
    logic rv1_nxt;
    logic rv2_r;
    logic rv2_nxt;
    logic [DATA_W-1:0] d2_r;
    logic [DATA_W-1:0] d2_nxt;
    logic [LANES-1:0] dqm_d1_r;
    logic [LANES-1:0] dqm_d1_nxt;
    logic out_v_r;
    logic out_v_nxt;
    logic [DATA_W-1:0] dq_out_r;
    logic [DATA_W-1:0] dq_out_nxt;
    logic [LANES-1:0] oe_r;
    logic [LANES-1:0] oe_nxt;
    logic cl3;

    // latency codes other than three run as two
    assign cl3 = read_latency_field == CL_3;

    always_comb begin
        rv1_nxt = beat_v && !beat_wr;
        rv2_nxt = rv1_r;
        d2_nxt = mif.rdata;
        dqm_d1_nxt = dqm_r;
        out_v_nxt = cl3 ? rv2_r : rv1_r;
        dq_out_nxt = cl3 ? d2_r : mif.rdata;
        // mask reaches the pins two clocks after it is sampled
        oe_nxt = {LANES{out_v_nxt}} & ~dqm_d1_r;
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            rv1_r <= 1'b0;
            rv2_r <= 1'b0;
            d2_r <= '0;
            dqm_d1_r <= '0;
            out_v_r <= 1'b0;
            dq_out_r <= '0;
            oe_r <= '0;
        end else begin
            rv1_r <= rv1_nxt;
            rv2_r <= rv2_nxt;
            d2_r <= d2_nxt;
            dqm_d1_r <= dqm_d1_nxt;
            out_v_r <= out_v_nxt;
            dq_out_r <= dq_out_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign o_bidirectional_data_lines = dq_out_r;
    assign o_bidirectional_data_lines_oe = oe_r;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    sequence s_rd_cl2;
        start_rd && !cl3 && !rv1_r;
    endsequence
    sequence s_rd_cl3;
        start_rd && cl3 && !rv1_r;
    endsequence
    sequence s_out_after_two;
        ##1 !out_v_r ##1 out_v_r;
    endsequence

    a_read_lat_two: assert property (s_rd_cl2 |-> s_out_after_two)
        else $error("read data not valid two clocks after command");
    a_read_lat_three: assert property (s_rd_cl3 |-> ##1 !out_v_r ##1 !out_v_r ##1 out_v_r)
        else $error("read data not valid three clocks after command");
    a_mode_load: assert property (cmd == CMD_LMR && ba_r == RS_BASE
        |=> mode_r == $past({ba_r, addr_r}))
        else $error("mode register not loaded");
    a_mode_hold: assert property (cmd != CMD_LMR |=> $stable(mode_r))
        else $error("mode register changed without load");
    a_active_row: assert property (cmd == CMD_ACT
        |=> open_r[$past(ba_r)] && row_r[$past(ba_r)] == $past(addr_r))
        else $error("active did not open addressed row");
    a_precharge_all: assert property (cmd == CMD_PRE && addr_r[AP_BIT]
        |=> o_all_banks_idle)
        else $error("banks not idle after precharge all");
    a_burst_limit: assert property (eng_r == ENG_BURST && !eng_full
        |-> eng_cnt_r <= eng_mask_r)
        else $error("burst exceeded programmed length");
    a_block_wrap: assert property (beat_v && !start
        |-> (beat_col & ~eng_mask_r) == (eng_start_r & ~eng_mask_r))
        else $error("burst left its block");
    a_interleave_order: assert property (beat_v && !start && eng_inter_r
        |-> ((beat_col ^ eng_start_r) & eng_mask_r) == (eng_cnt_r & eng_mask_r))
        else $error("interleaved order wrong");
    a_full_wrap: assert property (beat_v && !start && eng_full
        |-> beat_col == 9'(eng_start_r + eng_cnt_r))
        else $error("full row burst did not wrap in row");
    a_term_stops: assert property (eng_r == ENG_BURST && cmd == CMD_BST && !start
        |-> !beat_v ##1 eng_r == ENG_IDLE)
        else $error("burst terminate ignored");
    a_write_single: assert property (start_wr && write_burst_mode_bit
        |=> eng_r == ENG_IDLE)
        else $error("write burst not single in write burst mode");
endmodule : sdm_device

// ---- verification/sdm_ctrl_model.sv ----
`timescale 1ns/1ps
module sdm_ctrl_model (
    input wire logic i_mclk,
    output logic o_cs_n,
    output logic o_ras_n,
    output logic o_cas_n,
    output logic o_we_n,
    output logic o_ba0,
    output logic o_ba1,
    output logic [sdm_pkg::ROW_W-1:0] o_addr,
    output logic [sdm_pkg::DATA_W-1:0] o_dq
);
    import sdm_pkg::*;
    // ************
    // command driver
    // ************
    // 100 us of power-up wait at a 5 ns clock
    localparam int WAIT_CYC = 20000;
    // strobe codes {ras, cas, we}, indexed by command
    localparam logic [2:0] ENC [8] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h6, 3'h2, 3'h1, 3'h0};

    initial begin
        {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF; // inhibit from time zero
        {o_ba1, o_ba0} = 2'h0;
        o_addr = 13'h0000;
        o_dq = 16'h0000;
    end

    task automatic issue(input sdm_cmd_t c, input logic [1:0] ba, input logic [12:0] a,
            input logic drv, input logic [15:0] d);
        @(negedge i_mclk);
        o_cs_n = 1'b0;
        {o_ras_n, o_cas_n, o_we_n} = ENC[c];
        {o_ba1, o_ba0} = ba;
        o_addr = a;
        // a released bus must not keep showing the last word
        o_dq = drv ? d : ~o_dq;
    endtask : issue

    task automatic nop(input int n);
        repeat (n) issue(CMD_NOP, 2'h0, 13'h0000, 1'b0, 16'h0000);
    endtask : nop

    task automatic init();
        nop(WAIT_CYC);
        issue(CMD_PRE, 2'h0, 13'h0400, 1'b0, 16'h0000);
        repeat (2) begin
            nop(1);
            issue(CMD_REF, 2'h0, 13'h0000, 1'b0, 16'h0000);
        end
        nop(1);
    endtask : init

    task automatic load(input logic [12:0] m);
        issue(CMD_PRE, 2'h0, 13'h0400, 1'b0, 16'h0000);
        issue(CMD_LMR, RS_BASE, m & 13'h03FF, 1'b0, 16'h0000);
        nop(2);
    endtask : load

    task automatic open_row(input logic [1:0] ba, input logic [12:0] row);
        issue(CMD_ACT, ba, row, 1'b0, 16'h0000);
        nop(2);
    endtask : open_row

    // beats go out from the given column, so any burst order lands the same only when that column is a block start
    task automatic wr(input logic [1:0] ba, input logic [8:0] col, input int n,
            input logic [6:0] tag, input logic term);
        for (int i = 0; i < n; i++) begin
            logic [8:0] c;
            c = col + 9'(i);
            issue(i == 0 ? CMD_WR : CMD_NOP, ba, {4'h0, col}, 1'b1, {tag, c});
        end
        if (term) issue(CMD_BST, ba, 13'h0000, 1'b0, 16'h0000);
        nop(1);
    endtask : wr
endmodule : sdm_ctrl_model

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import sdm_pkg::*;
    localparam logic [1:0] BANK = 2'h2;
    localparam logic [12:0] ROW = 13'h1ABC;
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic cke = 1'b1;
    logic [LANES-1:0] dqm = 2'h0;
    logic cs_n, ras_n, cas_n, we_n, ba0, ba1, all_idle;
    logic [ROW_W-1:0] addr;
    logic [LANES-1:0] dq_oe;
    logic [DATA_W-1:0] dq_in, dq_out;
    logic [MODE_W-1:0] mode_reg;
    logic [6:0] shadow [512];
    int err_total = 0;
    int total_checks = 0;

    always #2.5 i_mclk = ~i_mclk;

    sdm_ctrl_model u_ctrl (.i_mclk(i_mclk), .o_cs_n(cs_n), .o_ras_n(ras_n),
        .o_cas_n(cas_n), .o_we_n(we_n), .o_ba0(ba0), .o_ba1(ba1), .o_addr(addr),
        .o_dq(dq_in));

    // clock gate high through init, dropped only in the gate scenario
    sdm_device u_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_cke(cke),
        .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
        .i_bank_select_bit0(ba0), .i_bank_select_bit1(ba1),
        .i_row_column_address_lines(addr), .i_dqm(dqm),
        .i_bidirectional_data_lines(dq_in), .o_bidirectional_data_lines(dq_out),
        .o_bidirectional_data_lines_oe(dq_oe), .o_all_banks_idle(all_idle),
        .o_operating_mode_register(mode_reg));

    // ************
    // checks and helpers
    // ************
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk16

    task automatic chk_mode(input logic [14:0] e);
        total_checks++;
        if (mode_reg !== e) begin
            $display("[FAIL] mode register expected %h seen %h", e, mode_reg);
            err_total++;
        end
    endtask : chk_mode

    function automatic logic [12:0] mode(input logic [2:0] bl, input logic bo,
            input logic [2:0] cl, input logic [1:0] opm, input logic wbm);
        mode = {3'h0, wbm, opm, cl, bo, bl};
    endfunction : mode

    task automatic tb_load(input logic [12:0] m);
        u_ctrl.load(m);
        chk_mode({2'h0, m});
        chk16("idle", 16'h0001, {15'h0000, all_idle});
        u_ctrl.open_row(BANK, ROW);
        chk16("idle", 16'h0000, {15'h0000, all_idle});
    endtask : tb_load

    // land: beats that really reach the array
    task automatic tb_wr(input logic [8:0] col, input int n, input int land,
            input logic [6:0] tag, input logic term);
        u_ctrl.wr(BANK, col, n, tag, term);
        for (int i = 0; i < land; i++) shadow[9'(col + 9'(i))] = tag;
    endtask : tb_wr

    task automatic rd(input logic [8:0] col, input int bl, input logic inter, input int cl);
        int k;
        int base;
        int off;
        logic [8:0] c;
        k = 1;
        base = col & ~(bl - 1);
        off = col & (bl - 1);
        u_ctrl.issue(CMD_RD, BANK, {4'h0, col}, 1'b0, 16'h0000);
        u_ctrl.nop(1);
        while (dq_oe === 2'h0 && k < 12) begin
            u_ctrl.nop(1);
            k++;
        end
        if (k == 12) begin
            err_total++;
            wrap_up();
        end
        chk16("latency", 16'(cl + 1), 16'(k));
        for (int i = 0; i < bl; i++) begin
            c = 9'(base | (inter ? (off ^ i) : ((off + i) & (bl - 1))));
            chk16("read word", {shadow[c], c}, dq_out);
            chk16("drive lanes", {14'h0000, ~dqm}, {14'h0000, dq_oe});
            u_ctrl.nop(1);
        end
        chk16("drive after burst", 16'h0000, {14'h0000, dq_oe});
    endtask : rd

    task automatic quiet(input string nm);
        repeat (8) begin
            u_ctrl.nop(1);
            chk16(nm, 16'h0000, {14'h0000, dq_oe});
        end
    endtask : quiet

    // ************
    // scenarios
    // ************
    task automatic t_basic();
        chk_mode(15'h0000);
        chk16("reset idle", 16'h0001, {15'h0000, all_idle});
        u_ctrl.init();
        tb_load(mode(BL_8, 1'b0, 3'h2, OPM_NORMAL, 1'b0));
        tb_wr(9'h008, 8, 8, 7'h11, 1'b0);
        rd(9'h00D, 8, 1'b0, 2);
        $display("basic done");
    endtask : t_basic

    // lengths 1, 2, 4 and 8 with both orders, latency two and three
    task automatic t_lengths();
        logic [2:0] codes [4];
        codes = '{BL_1, BL_2, BL_4, BL_8};
        for (int j = 0; j < 8; j++) begin
            tb_load(mode(codes[j / 2], 1'(j % 2), (j % 2) ? CL_3 : 3'h2, OPM_NORMAL, 1'b0));
            rd(9'h00B, 1 << (j / 2), 1'(j % 2), (j % 2) ? 3 : 2);
        end
        $display("lengths done");
    endtask : t_lengths

    task automatic t_full();
        tb_load(mode(BL_8, 1'b0, 3'h2, OPM_NORMAL, 1'b0));
        tb_wr(9'h000, 8, 8, 7'h22, 1'b0);
        tb_load(mode(BL_FULL, 1'b0, 3'h2, OPM_NORMAL, 1'b0));
        tb_wr(9'h1FE, 4, 4, 7'h33, 1'b1);
        tb_load(mode(BL_2, 1'b0, 3'h2, OPM_NORMAL, 1'b0));
        rd(9'h1FF, 2, 1'b0, 2);
        rd(9'h001, 2, 1'b0, 2);
        rd(9'h002, 2, 1'b0, 2);
        $display("full row done");
    endtask : t_full

    task automatic t_wbm();
        tb_load(mode(BL_4, 1'b0, 3'h2, OPM_NORMAL, 1'b1));
        tb_wr(9'h008, 4, 1, 7'h44, 1'b0);
        rd(9'h009, 4, 1'b0, 2);
        $display("write mode done");
    endtask : t_wbm

    // masked low lane on a read, then a read while the clock gate is low
    task automatic t_gate();
        dqm = 2'h1;
        rd(9'h009, 4, 1'b0, 2);
        dqm = 2'h0;
        cke = 1'b0;
        u_ctrl.issue(CMD_RD, BANK, 13'h0009, 1'b0, 16'h0000);
        quiet("gated read");
        cke = 1'b1;
        $display("gate done");
    endtask : t_gate

    task automatic t_refuse();
        tb_load(mode(BL_4, 1'b0, 3'h2, 2'h1, 1'b0));
        u_ctrl.issue(CMD_RD, BANK, 13'h0008, 1'b0, 16'h0000);
        quiet("test mode read");
        tb_load(mode(BL_4, 1'b0, 3'h2, OPM_NORMAL, 1'b0));
        u_ctrl.issue(CMD_RD, 2'h1, 13'h0008, 1'b0, 16'h0000);
        quiet("closed bank read");
        u_ctrl.issue(CMD_LMR, 2'h1, 13'h0033, 1'b0, 16'h0000);
        u_ctrl.nop(2);
        chk_mode({2'h0, mode(BL_4, 1'b0, 3'h2, OPM_NORMAL, 1'b0)});
        $display("refusals done");
    endtask : t_refuse

    initial begin
        repeat (3) @(negedge i_mclk);
        i_sys_rst = 1'b0;
        t_basic();
        t_lengths();
        t_full();
        t_wbm();
        t_gate();
        t_refuse();
        wrap_up();
    end
endmodule : testbench
